// file: src/tcoc_top.sv
/*
 * Timer capture and output control: register roles and capture triggers,
 * output flip-flop with one-shot control, prescaler and input edge logic.
 * Assumes an external up_counter that consumes the events and reports
 * its mode, matches and overflow on the same clock.
 */
`timescale 1ns/1ps

// Operation
// - Second register compares when role bit is 0, captures when 1.
// - First register trigger: second pin edge at 0, first pin opposite edge at 1.
// - First register compares when role bit is 0, captures when 1.
// - No capture from first pin edges when its valid edge is both edges.
// - Capture trigger sampled by count clock; short pulses rejected.
// - Writing 1 to soft trigger fires one-shot; bit reads 0.
// - One-shot mode bit: 0 successive pulses, 1 one-shot.
// - One-shot works only in free-running and clear-on-edge modes.
// - Output inverts on second match when its enable is 1.
// - Output inverts on first match when its enable is 1.
// - Level field 01 resets, 10 sets output; bits read 0.
// - Output pin forced 0 when output enable is 0.
// - Each pin has edge code: 00 fall, 01 rise, 11 both.
// - Count clock is main clock /2, /4, /256 or first pin edge.
// - Pin high after reset gives a rising edge at first enable only.
module tcoc_top (
   input  wire logic              mclk,        // Main clock, 25 MHz
   input  wire logic              reset,       // Synchronous reset, high
   input  wire logic [15:0]       regAddr,     // Register address
   input  wire logic [7:0]        regWdata,    // Register write data
   input  wire logic              regWr,       // Write strobe
   input  wire logic              regRd,       // Read strobe
   output logic      [7:0]        regRdata,    // Read data, next cycle
   input  wire logic              firstInputPin,  // Asynchronous input pin
   input  wire logic              secondInputPin, // Asynchronous input pin
   input  wire tcoc_pkg::tcoc_cnt_t cntIn,     // Counter status
   output tcoc_pkg::tcoc_evt_t    evtOut,      // Counter events and roles
   output logic                   timerOutputPin // Timer output pin
);

   // Edge hit for a two-bit valid-edge code
   function automatic logic edgeHit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
      logic hit;
      case (sel)
         tcoc_pkg::EDGE_FALL: hit = fall;
         tcoc_pkg::EDGE_RISE: hit = rise;
         tcoc_pkg::EDGE_BOTH: hit = rise | fall;
         default:             hit = 1'b0;   // Prohibited code
      endcase
      return hit;
   endfunction

   logic [2:0] ccc_ff;          // Role and trigger selects
   logic       outEn_ff;        // Output enable
   logic       firstInv_ff;     // First match invert enable
   logic       secondInv_ff;    // Second match invert enable
   logic       oneshotMode_ff;  // One-shot mode select
   logic [7:0] psc_ff;          // Edge and count clock selects
   logic [1:0] pinS1_ff;        // Synchroniser stage 1
   logic [1:0] pinS2_ff;        // Synchroniser stage 2
   logic [1:0] pinS3_ff;        // Synchroniser stage 3
   logic [1:0] pinLvl_ff;       // Agreed pin level
   logic       extPrev_ff;      // Previous first pin level, clock path
   logic [1:0] smp_ff;          // Level seen at last count tick
   logic [1:0] filt_ff;         // Filtered pin level
   logic [1:0] filtPrev_ff;     // Previous filtered level
   logic       seenRun_ff;      // Counter has run since reset
   logic [7:0] div_ff;          // Prescaler counter
   logic       armed_ff;        // One-shot window open
   logic       outFf_ff;        // Timer output flip-flop
   logic       softTrig;        // Soft trigger write
   logic       run;             // Counter running
   logic       tick;            // Count clock this cycle
   logic       extEdge;         // First pin valid edge, unfiltered
   logic [1:0] rise;            // Filtered rising edges
   logic [1:0] fall;            // Filtered falling edges
   logic       firstValid;      // First pin filtered valid edge
   logic       secondValid;     // Second pin filtered valid edge
   logic       firstOpp;        // First pin opposite-phase edge
   logic       invAllow;        // Inversions allowed now
   logic       nxt_outFf;       // Next output flip-flop
   logic       nxt_outEn;       // Next output enable
   logic       oneshotStart;    // One-shot start request

   wire  [1:0] firstEdge  = psc_ff[tcoc_pkg::FIRST_EDGE_LSB +: 2];
   wire  [1:0] secondEdge = psc_ff[tcoc_pkg::SECOND_EDGE_LSB +: 2];
   wire  [1:0] clkSel     = psc_ff[tcoc_pkg::CLK_SEL_LSB +: 2];
   wire        firstBoth  = (firstEdge == tcoc_pkg::EDGE_BOTH);

   assign run = (cntIn.mode != tcoc_pkg::MODE_STOP);
   assign softTrig = regWr && (regAddr == tcoc_pkg::TOC_ADDR)
                     && regWdata[tcoc_pkg::SOFT_TRIG_BIT];

   // Register writes; the timer is assumed stopped for these
   always_ff @(posedge mclk) begin
      if (reset) begin
         ccc_ff         <= tcoc_pkg::CCC_RST[2:0];
         outEn_ff       <= tcoc_pkg::TOC_RST[tcoc_pkg::OUT_EN_BIT];
         firstInv_ff    <= tcoc_pkg::TOC_RST[tcoc_pkg::FIRST_INV_BIT];
         secondInv_ff   <= tcoc_pkg::TOC_RST[tcoc_pkg::SECOND_INV_BIT];
         oneshotMode_ff <= tcoc_pkg::TOC_RST[tcoc_pkg::ONESHOT_MODE_BIT];
         psc_ff         <= tcoc_pkg::PSC_RST;
      end else if (regWr) begin
         case (regAddr)
            tcoc_pkg::CCC_ADDR: ccc_ff <= regWdata[2:0];
            tcoc_pkg::TOC_ADDR: begin
               outEn_ff       <= regWdata[tcoc_pkg::OUT_EN_BIT];
               firstInv_ff    <= regWdata[tcoc_pkg::FIRST_INV_BIT];
               secondInv_ff   <= regWdata[tcoc_pkg::SECOND_INV_BIT];
               oneshotMode_ff <= regWdata[tcoc_pkg::ONESHOT_MODE_BIT];
            end
            tcoc_pkg::PSC_ADDR: psc_ff <= regWdata & 8'hf3;
            default: ;
         endcase
      end
   end

   // Read data; level bits and soft trigger read 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            tcoc_pkg::CCC_ADDR: regRdata <= {5'h00, ccc_ff};
            tcoc_pkg::TOC_ADDR: regRdata <= {2'b00, oneshotMode_ff,
                                             secondInv_ff, 2'b00,
                                             firstInv_ff, outEn_ff};
            tcoc_pkg::PSC_ADDR: regRdata <= psc_ff;
            default:            regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   // Three-stage pin synchroniser; level changes when stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinS1_ff  <= 2'b00;
         pinS2_ff  <= 2'b00;
         pinS3_ff  <= 2'b00;
         pinLvl_ff <= 2'b00;
      end else begin
         pinS1_ff <= {secondInputPin, firstInputPin};
         pinS2_ff <= pinS1_ff;
         pinS3_ff <= pinS2_ff;
         for (int i = 0; i < 2; i++) begin
            if (pinS2_ff[i] == pinS3_ff[i]) begin
               pinLvl_ff[i] <= pinS2_ff[i];
            end
         end
      end
   end

   // Prescaler counter runs only while the counter runs
   always_ff @(posedge mclk) begin
      if (reset || !run) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // External clock edge uses the main-clock sampled level
   always_ff @(posedge mclk) begin
      if (reset) begin
         extPrev_ff <= 1'b0;
      end else begin
         extPrev_ff <= pinLvl_ff[0];
      end
   end

   assign extEdge = edgeHit(firstEdge, pinLvl_ff[0] & ~extPrev_ff,
                            ~pinLvl_ff[0] & extPrev_ff);

   // Count clock selection
   always_comb begin
      case (clkSel)
         tcoc_pkg::CLK_DIV2:   tick = (div_ff & tcoc_pkg::DIV2_MASK)
                                      == tcoc_pkg::DIV2_MASK;
         tcoc_pkg::CLK_DIV4:   tick = (div_ff & tcoc_pkg::DIV4_MASK)
                                      == tcoc_pkg::DIV4_MASK;
         tcoc_pkg::CLK_DIV256: tick = (div_ff == tcoc_pkg::DIV256_MASK);
         default:              tick = extEdge;
      endcase
      tick = tick & run;
   end

   // Remember that the counter has run once since reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         seenRun_ff <= 1'b0;
      end else if (run) begin
         seenRun_ff <= 1'b1;
      end
   end

   // Noise filter: level accepted after two equal count clock samples
   // Levels start at 0 so a high pin gives a rising edge at first run,
   // while a stop after that tracks the pin to hide it
   always_ff @(posedge mclk) begin
      if (reset) begin
         smp_ff      <= 2'b00;
         filt_ff     <= 2'b00;
         filtPrev_ff <= 2'b00;
      end else if (!run) begin
         if (seenRun_ff) begin
            smp_ff      <= pinLvl_ff;
            filt_ff     <= pinLvl_ff;
            filtPrev_ff <= pinLvl_ff;
         end
      end else begin
         filtPrev_ff <= filt_ff;
         if (tick) begin
            smp_ff <= pinLvl_ff;
            for (int i = 0; i < 2; i++) begin
               if (smp_ff[i] == pinLvl_ff[i]) begin
                  filt_ff[i] <= pinLvl_ff[i];
               end
            end
         end
      end
   end

   assign rise = filt_ff & ~filtPrev_ff;
   assign fall = ~filt_ff & filtPrev_ff;

   // Valid edges per pin selector
   assign firstValid  = edgeHit(firstEdge, rise[0], fall[0]);
   assign secondValid = edgeHit(secondEdge, rise[1], fall[1]);
   // Opposite phase of the first pin edge; none with both edges
   assign firstOpp = (firstEdge == tcoc_pkg::EDGE_FALL) ? rise[0] :
                     (firstEdge == tcoc_pkg::EDGE_RISE) ? fall[0] : 1'b0;

   // One-shot start: soft trigger, or pin edge in clear-on-edge mode
   assign oneshotStart = oneshotMode_ff && run &&
                         (softTrig ||
                          (cntIn.mode == tcoc_pkg::MODE_CLR_EDGE && firstValid));

   // One-shot window, never opened in clear-on-match mode
   always_ff @(posedge mclk) begin
      if (reset || !oneshotMode_ff ||
          cntIn.mode == tcoc_pkg::MODE_CLR_MATCH ||
          cntIn.mode == tcoc_pkg::MODE_STOP) begin
         armed_ff <= 1'b0;
      end else if (oneshotStart) begin
         armed_ff <= 1'b1;
      end else if (cntIn.overflow) begin
         armed_ff <= 1'b0;
      end
   end

   assign invAllow = !oneshotMode_ff || armed_ff;

   // Output flip-flop: any timer_output_control write wins, else match inversions
   always_comb begin
      nxt_outFf = outFf_ff;
      nxt_outEn = outEn_ff;
      if (regWr && regAddr == tcoc_pkg::TOC_ADDR) begin
         nxt_outEn = regWdata[tcoc_pkg::OUT_EN_BIT];
         case ({regWdata[tcoc_pkg::LVL_SET_BIT],
                regWdata[tcoc_pkg::LVL_RESET_BIT]})
            2'b01:   nxt_outFf = 1'b0;
            2'b10:   nxt_outFf = 1'b1;
            default: nxt_outFf = outFf_ff;
         endcase
      end else if (invAllow) begin
         nxt_outFf = outFf_ff
                     ^ (cntIn.secondMatch & secondInv_ff)
                     ^ (cntIn.firstMatch & firstInv_ff);
      end
   end

   // Output flip-flop and gated pin, both registered
   always_ff @(posedge mclk) begin
      if (reset) begin
         outFf_ff       <= 1'b0;
         timerOutputPin <= 1'b0;
      end else begin
         outFf_ff       <= nxt_outFf;
         timerOutputPin <= nxt_outEn & nxt_outFf;
      end
   end

   // Counter events and register roles
   always_ff @(posedge mclk) begin
      if (reset) begin
         evtOut <= '0;
      end else begin
         evtOut.countTick       <= tick;
         evtOut.firstIsCapture  <= ccc_ff[tcoc_pkg::FIRST_ROLE_BIT];
         evtOut.secondIsCapture <= ccc_ff[tcoc_pkg::SECOND_ROLE_BIT];
         evtOut.firstCapture    <= run && ccc_ff[tcoc_pkg::FIRST_ROLE_BIT] &&
                                   (ccc_ff[tcoc_pkg::FIRST_TRIG_BIT] ?
                                    firstOpp : secondValid);
         evtOut.secondCapture   <= run && ccc_ff[tcoc_pkg::SECOND_ROLE_BIT] &&
                                   !firstBoth && firstValid;
         evtOut.clearStart      <= oneshotStart ||
                                   (run && cntIn.mode == tcoc_pkg::MODE_CLR_EDGE
                                    && firstValid);
      end
   end

endmodule

// file: inc/tcoc_pkg.sv
/*
 * Package of the timer capture and output control block: register
 * addresses, field positions, reset values, edge and clock codes.
 * Assumes an 8-bit register port with 16-bit addresses.
 */
package tcoc_pkg;
   // Register addresses
   localparam logic [15:0] CCC_ADDR = 16'hff6a;   // capture_compare_control
   localparam logic [15:0] TOC_ADDR = 16'hff6b;   // timer_output_control
   localparam logic [15:0] PSC_ADDR = 16'hff7f;   // count_clock_and_edge_select
   // Reset values
   localparam logic [7:0]  CCC_RST  = 8'h00;
   localparam logic [7:0]  TOC_RST  = 8'h00;
   localparam logic [7:0]  PSC_RST  = 8'h00;
   // capture_compare_control fields
   localparam int FIRST_ROLE_BIT    = 0;
   localparam int FIRST_TRIG_BIT    = 1;
   localparam int SECOND_ROLE_BIT   = 2;
   // timer_output_control fields
   localparam int OUT_EN_BIT        = 0;
   localparam int FIRST_INV_BIT     = 1;
   localparam int LVL_RESET_BIT     = 2;
   localparam int LVL_SET_BIT       = 3;
   localparam int SECOND_INV_BIT    = 4;
   localparam int ONESHOT_MODE_BIT  = 5;
   localparam int SOFT_TRIG_BIT     = 6;
   // count_clock_and_edge_select fields
   localparam int CLK_SEL_LSB       = 0;
   localparam int FIRST_EDGE_LSB    = 4;
   localparam int SECOND_EDGE_LSB   = 6;
   // Valid-edge codes
   localparam logic [1:0] EDGE_FALL = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_BOTH = 2'b11;
   // Count clock codes
   localparam logic [1:0] CLK_DIV2   = 2'b00;
   localparam logic [1:0] CLK_DIV4   = 2'b01;
   localparam logic [1:0] CLK_DIV256 = 2'b10;
   localparam logic [1:0] CLK_EXT    = 2'b11;
   // Prescaler terminal counts
   localparam logic [7:0] DIV2_MASK   = 8'h01;
   localparam logic [7:0] DIV4_MASK   = 8'h03;
   localparam logic [7:0] DIV256_MASK = 8'hff;

   // Counter operating mode, supplied by the mode register outside
   typedef enum logic [1:0] {
      MODE_STOP      = 2'b00,
      MODE_FREE      = 2'b01,
      MODE_CLR_EDGE  = 2'b10,
      MODE_CLR_MATCH = 2'b11
   } tcoc_mode_t;

   // Status coming from the up_counter and its comparators
   typedef struct packed {
      tcoc_mode_t mode;          // Operating mode
      logic       firstMatch;    // Counter equals first register, pulse
      logic       secondMatch;   // Counter equals second register, pulse
      logic       overflow;      // Counter wraps, pulse
   } tcoc_cnt_t;

   // Events and levels sent to the counter datapath
   typedef struct packed {
      logic countTick;           // Count clock enable, pulse
      logic firstCapture;        // Load first register, pulse
      logic secondCapture;       // Load second register, pulse
      logic clearStart;          // Clear and restart counter, pulse
      logic firstIsCapture;      // First register role, level
      logic secondIsCapture;     // Second register role, level
   } tcoc_evt_t;
endpackage

// file: verification/tcoc_pin_src.sv
/* Pulse source that stands in for the devices on the two timer input pins.
   Assumes the bench calls pulse() and that mclk is the block's clock. */
`timescale 1ns/1ps
module tcoc_pin_src (
   input  wire logic mclk,      // Main clock
   output logic      pinFirst,  // Drives firstInputPin
   output logic      pinSecond  // Drives secondInputPin
);
   // Both pins rest low between pulses
   initial begin
      pinFirst = 1'b0;
      pinSecond = 1'b0;
   end
   // One high pulse of w clocks, then w clocks low so back-to-back pulses
   // stay apart; callers keep w well above two count clocks, save the short-pulse case
   task automatic pulse(input int which, input int w);
      @(posedge mclk);
      if (which == 0) pinFirst <= 1'b1;
      else pinSecond <= 1'b1;
      repeat (w) @(posedge mclk);
      if (which == 0) pinFirst <= 1'b0;
      else pinSecond <= 1'b0;
      repeat (w) @(posedge mclk);
   endtask
endmodule

// file: verification/tcoc_top_asserts.sv
/* Port checker for tcoc_top.
   Bound to tcoc_top below; sees only its ports. */
`timescale 1ns/1ps
module tcoc_top_asserts (
   input wire logic                 mclk,           // Main clock
   input wire logic                 reset,          // Sync reset
   input wire logic [15:0]          regAddr,        // Address
   input wire logic [7:0]           regWdata,       // Write data
   input wire logic                 regWr,          // Write strobe
   input wire logic                 regRd,          // Read strobe
   input wire logic [7:0]           regRdata,       // Read data
   input wire logic                 firstInputPin,  // Pin
   input wire logic                 secondInputPin, // Pin
   input wire tcoc_pkg::tcoc_cnt_t  cntIn,          // Counter status
   input wire tcoc_pkg::tcoc_evt_t  evtOut,         // Events
   input wire logic                 timerOutputPin  // Output pin
);
   logic [7:0] cccFf;
   logic [7:0] tocFf;
   logic [7:0] pscFf;
   logic       tocWr;
   logic       bothSel;
   logic       run;
   assign tocWr = regWr && regAddr == tcoc_pkg::TOC_ADDR;
   assign bothSel = pscFf[5:4] == 2'b11;
   assign run = cntIn.mode == tcoc_pkg::MODE_FREE;
   // Shadow copies of the control bytes as written
   always_ff @(posedge mclk) begin
      if (reset) begin
         cccFf <= 8'h00;
         tocFf <= 8'h00;
         pscFf <= 8'h00;
      end else if (regWr) begin
         if (regAddr == tcoc_pkg::CCC_ADDR) cccFf <= regWdata;
         if (tocWr) tocFf <= regWdata;
         if (regAddr == tcoc_pkg::PSC_ADDR) pscFf <= regWdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_toc_readback: assert property (
      $past(regRd) && $past(regAddr) == tcoc_pkg::TOC_ADDR |-> regRdata[6] == 1'b0
      && regRdata[3:2] == 2'b00) else $error("trigger or level bits read nonzero");
   a_pin_gated: assert property (!tocFf[0] |-> !timerOutputPin)
      else $error("output pin high while disabled");
   a_level_write: assert property (
      tocWr && tocFf[0] && regWdata[0] && regWdata[3] != regWdata[2]
      |=> timerOutputPin == $past(regWdata[3])) else $error("level write ignored");
   a_first_role: assert property (
      !$past(regWr) && !$past(regWr, 2) |-> evtOut.firstIsCapture == cccFf[0])
      else $error("first register role wrong");
   a_second_role: assert property (
      !$past(regWr) && !$past(regWr, 2) |-> evtOut.secondIsCapture == cccFf[2])
      else $error("second register role wrong");
   a_second_invert: assert property (
      cntIn.secondMatch && !cntIn.firstMatch && tocFf[4] && tocFf[0] && !tocFf[5]
      && run && !regWr |=> timerOutputPin != $past(timerOutputPin))
      else $error("no inversion on second match");
   a_first_invert: assert property (
      cntIn.firstMatch && !cntIn.secondMatch && tocFf[1] && tocFf[0] && !tocFf[5]
      && run && !regWr |=> timerOutputPin != $past(timerOutputPin))
      else $error("no inversion on first match");
   a_no_invert: assert property (
      (cntIn.firstMatch || cntIn.secondMatch) && !(cntIn.firstMatch && tocFf[1])
      && !(cntIn.secondMatch && tocFf[4]) && !cntIn.overflow && !regWr
      |=> $stable(timerOutputPin)) else $error("inversion while disabled");
   a_soft_start: assert property (
      tocWr && regWdata[6] && regWdata[5] && tocFf[5] && run |=> evtOut.clearStart)
      else $error("soft trigger gave no start");
   a_both_nocap: assert property (
      bothSel && $past(bothSel, 4) |-> !evtOut.secondCapture
      && !(cccFf[1] && evtOut.firstCapture)) else $error("capture on both edges");
   c_second_cap: cover property (evtOut.secondCapture);
   c_first_cap: cover property (evtOut.firstCapture);
   c_start: cover property (evtOut.clearStart);
endmodule
bind tcoc_top tcoc_top_asserts u_chk (.mclk(mclk), .reset(reset), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .firstInputPin(firstInputPin), .secondInputPin(secondInputPin), .cntIn(cntIn),
   .evtOut(evtOut), .timerOutputPin(timerOutputPin));

// file: verification/tcoc_top_test.sv
/* Self-checking bench of tcoc_top with a pulse source on the input pins.
   Assumes the bench plays the register master and the counter status. */
`timescale 1ns/1ps
module tcoc_top_test;
   logic                mclk;
   logic                reset;
   logic [15:0]         regAddr;
   logic [7:0]          regWdata;
   logic                regWr;
   logic                regRd;
   logic [7:0]          regRdata;
   logic                pinFirst;
   logic                pinSecond;
   tcoc_pkg::tcoc_cnt_t cntIn;
   tcoc_pkg::tcoc_evt_t evtOut;
   logic                timerOutputPin;
   logic [7:0]          rv;
   int                  err_total;
   int                  checks;
   int                  n;
   tcoc_top u_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .firstInputPin(pinFirst),
      .secondInputPin(pinSecond), .cntIn(cntIn), .evtOut(evtOut),
      .timerOutputPin(timerOutputPin));
   tcoc_pin_src u_src (.mclk(mclk), .pinFirst(pinFirst), .pinSecond(pinSecond));
   // Clock at 40 ns
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // Wait k edges, then settle
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Count pulses on event bit k over w clocks
   task automatic cnt(input int k, input int w, output int c);
      c = 0;
      repeat (w) begin
         @(posedge mclk);
         #1 if (evtOut[k] === 1'b1) c++;
      end
   endtask
   task automatic setup(input logic [7:0] ccc, input logic [7:0] psc);
      cntIn.mode <= tcoc_pkg::MODE_STOP;
      wr(tcoc_pkg::CCC_ADDR, ccc);
      wr(tcoc_pkg::PSC_ADDR, psc);
      cntIn.mode <= tcoc_pkg::MODE_FREE;
   endtask
   task automatic t_regs();
      rd(tcoc_pkg::CCC_ADDR, rv); chk(rv, tcoc_pkg::CCC_RST, "ccc reset");
      rd(tcoc_pkg::TOC_ADDR, rv); chk(rv, tcoc_pkg::TOC_RST, "toc reset");
      rd(tcoc_pkg::PSC_ADDR, rv); chk(rv, tcoc_pkg::PSC_RST, "psc reset");
      wr(tcoc_pkg::PSC_ADDR, 8'hff);
      rd(tcoc_pkg::PSC_ADDR, rv); chk(rv, 8'hf3, "psc readback");
      wr(tcoc_pkg::CCC_ADDR, 8'hff);
      rd(tcoc_pkg::CCC_ADDR, rv); chk(rv, 8'h07, "ccc readback");
      tick(2); chk(evtOut.firstIsCapture, 1'b1, "first role");
      chk(evtOut.secondIsCapture, 1'b1, "second role");
      wr(16'hff00, 8'h55);
      rd(16'hff00, rv); chk(rv, 8'h00, "unmapped");
      $display("t_regs done");
   endtask
   task automatic t_output();
      wr(tcoc_pkg::TOC_ADDR, 8'h01);
      wr(tcoc_pkg::TOC_ADDR, 8'h09); tick(1);
      chk(timerOutputPin, 1'b1, "level set");
      rd(tcoc_pkg::TOC_ADDR, rv); chk(rv, 8'h01, "level bits read");
      wr(tcoc_pkg::TOC_ADDR, 8'h00); tick(1);
      chk(timerOutputPin, 1'b0, "pin gated");
      wr(tcoc_pkg::TOC_ADDR, 8'h13);
      wr(tcoc_pkg::TOC_ADDR, 8'h17); tick(1);
      chk(timerOutputPin, 1'b0, "level reset");
      cntIn.mode <= tcoc_pkg::MODE_FREE;
      @(posedge mclk) cntIn.secondMatch <= 1'b1;
      @(posedge mclk) cntIn.secondMatch <= 1'b0;
      tick(1); chk(timerOutputPin, 1'b1, "second invert");
      @(posedge mclk) cntIn.firstMatch <= 1'b1;
      @(posedge mclk) cntIn.firstMatch <= 1'b0;
      tick(1); chk(timerOutputPin, 1'b0, "first invert");
      cntIn.mode <= tcoc_pkg::MODE_STOP;
      wr(tcoc_pkg::TOC_ADDR, 8'h01);
      cntIn.mode <= tcoc_pkg::MODE_FREE;
      @(posedge mclk) cntIn.firstMatch <= 1'b1;
      @(posedge mclk) cntIn.firstMatch <= 1'b0;
      tick(1); chk(timerOutputPin, 1'b0, "invert disabled");
      $display("t_output done");
   endtask
   task automatic t_oneshot();
      cntIn.mode <= tcoc_pkg::MODE_STOP;
      wr(tcoc_pkg::TOC_ADDR, 8'h21);
      cntIn.mode <= tcoc_pkg::MODE_FREE;
      fork
         wr(tcoc_pkg::TOC_ADDR, 8'h61);
         cnt(2, 4, n);
      join
      chk(16'(n), 16'd1, "soft start");
      tick(4);
      rd(tcoc_pkg::TOC_ADDR, rv); chk(rv, 8'h21, "trigger reads 0");
      $display("t_oneshot done");
   endtask
   task automatic t_capture();
      setup(8'h04, 8'h10);
      fork u_src.pulse(0, 12); cnt(3, 40, n); join
      chk(16'(n), 16'd1, "second capture");
      fork u_src.pulse(0, 2); cnt(3, 40, n); join
      chk(16'(n), 16'd0, "short pulse");
      setup(8'h04, 8'h30);
      fork u_src.pulse(0, 12); cnt(3, 40, n); join
      chk(16'(n), 16'd0, "both edges");
      setup(8'h01, 8'h40);
      fork u_src.pulse(1, 12); cnt(4, 40, n); join
      chk(16'(n), 16'd1, "second pin trigger");
      setup(8'h03, 8'h00);
      fork u_src.pulse(0, 12); cnt(4, 40, n); join
      chk(16'(n), 16'd1, "opposite phase");
      cntIn.mode <= tcoc_pkg::MODE_CLR_EDGE;
      fork u_src.pulse(0, 12); cnt(2, 40, n); join
      chk(16'(n), 16'd1, "clear on edge");
      $display("t_capture done");
   endtask
   // Pin held high across a second reset: edge at first run only
   task automatic t_restart();
      fork
         u_src.pulse(0, 200);
         begin
            tick(10);
            reset <= 1'b1;
            cntIn.mode <= tcoc_pkg::MODE_STOP;
            tick(20);
            reset <= 1'b0;
            setup(8'h04, 8'h10);
            cnt(3, 40, n); chk(16'(n), 16'd1, "edge after reset");
            setup(8'h04, 8'h10);
            cnt(3, 40, n); chk(16'(n), 16'd0, "no edge on restart");
         end
      join
      $display("t_restart done");
   endtask
   task automatic t_clock();
      int div [3] = '{2, 4, 256};
      for (int i = 0; i < 3; i++) begin
         setup(8'h00, 8'(i));
         cnt(5, 1024, n); chk(16'(n), 16'(1024 / div[i]), "divided tick");
      end
      setup(8'h00, 8'h13);
      fork
         repeat (3) u_src.pulse(0, 8);
         cnt(5, 60, n);
      join
      chk(16'(n), 16'd3, "external tick");
      $display("t_clock done");
   endtask
   task automatic give_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
   // Main sequence
   initial begin
      err_total = 0;
      checks = 0;
      reset = 1'b1;
      regAddr = 16'h0000;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      cntIn = '0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      t_regs();
      t_output();
      t_oneshot();
      t_capture();
      t_restart();
      t_clock();
      give_verdict();
   end
endmodule
